/* xbus_control.sv */
// How it works
// - Config RAM read strobe low on master I/O reads inside the programmed range.
// - Config RAM write strobe low on master I/O writes inside range, high otherwise.
// - Direction high for master I/O and memory reads.
// - Channel 2 DMA memory-read/I/O-write with BIOS select drives direction high.
// - Channel 2 DMA I/O-read/memory-write with DOR bit 3 set drives direction high.
// - Direction low in every other case.
// - Master memory cycles enable transceiver only with BIOS select.
// - Master I/O cycles enable transceiver for enabled, decoded peripherals.
// - No enable for reads of 3F7h/377h while IDE decode is off.
// - No enable for floppy I/O when the disk-change strap read low.
// - DMA cycles enable transceiver only on channel 2.
// - Mode bit 4 picks one-hot selects or encoded select code.
// - One-hot selects assert on master I/O inside their base/mask windows.
// - Encoded mode outputs a 3-bit code for an outside 3-to-8 decoder.
// - Select pin 0 is an input in reset, sampled at release for test/init.
// - After reset select pin 0 is driven again as a normal select.
// - Disk-change strap captured at reset release; high means floppy present.

`timescale 1ns/100ps

module xbus_control
    import xbus_pkg::*;
#(
    parameter int N = GP_COUNT
)
(
    // Clock, reset and enable
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              ce,
    // Current bus cycle, latched address
    input  wire cycle_type         bus_cycle,
    // Configuration
    input  wire logic [ADDR_W-1:0] cram_low,
    input  wire logic [ADDR_W-1:0] cram_high,
    input  wire window_type [N-1:0] gp_window,
    input  wire logic [7:0]        mode_select,
    input  wire logic [7:0]        floppy_dor,
    input  wire logic              ide_enable,
    input  wire hits_type          periph_hits,
    input  wire logic              local_bios_select_n,
    // Strap pins
    input  wire logic              disk_change_strap,
    input  wire logic              select0_in,
    // Config RAM strobes
    output logic                   cfg_ram_read_strobe_n,
    output logic                   cfg_ram_write_strobe_n,
    // Transceiver control
    output logic                   periph_xcvr_direction,
    output logic                   periph_xcvr_output_enable_n,
    // Shared select pins, general_select_n or encoded_select_code
    output logic [2:0]             select_out,
    output logic                   select0_oe,
    // Captured straps
    output logic                   test_mode_select,
    output logic                   floppy_present
);

    // ************************************************************
    // Decode
    // ************************************************************
    logic         cram_hit;
    logic [N-1:0] window_hit;
    logic         status_addr;

    xbus_decode #(
        .N           (N)
    ) u_decode (
        .address     (bus_cycle.address),
        .cram_low    (cram_low),
        .cram_high   (cram_high),
        .windows     (gp_window),
        .cram_hit    (cram_hit),
        .window_hit  (window_hit),
        .status_addr (status_addr)
    );

    // Fixed priority: serial, parallel, IDE, then general windows
    function automatic logic [2:0] encode_select(
        input hits_type     h,
        input logic [N-1:0] w
    );
        encode_select = CODE_IDLE;
        if (h.serial_a)
            encode_select = CODE_SERIAL_A;
        else if (h.serial_b)
            encode_select = CODE_SERIAL_B;
        else if (h.parallel)
            encode_select = CODE_PARALLEL;
        else if (h.ide)
            encode_select = CODE_IDE;
        else
        begin
            for (int k = N - 1; k >= 0; k--)
            begin
                if (w[k])
                    encode_select = CODE_GP0 + 3'(k);
            end
        end
    endfunction

    // ************************************************************
    // Cycle classes
    // ************************************************************
    logic master;
    logic io_cyc;
    logic mem_cyc;
    logic ch2;
    logic bios_sel;
    logic dir_master;
    logic dir_bios;
    logic dir_dor;
    logic io_oe;
    logic oe;
    logic encoded;
    logic [2:0] onehot_n;
    logic [2:0] code;
    state_type  state;
    state_type  next_state;

    assign master   = !bus_cycle.dma;
    assign io_cyc   = bus_cycle.io_read || bus_cycle.io_write;
    assign mem_cyc  = bus_cycle.mem_read || bus_cycle.mem_write;
    assign ch2      = bus_cycle.dma && (bus_cycle.dma_channel == DMA_FDC_CHANNEL);
    assign bios_sel = !local_bios_select_n;
    assign encoded  = mode_select[MODE_ENC_BIT];

    assign dir_master = master && (bus_cycle.io_read || bus_cycle.mem_read);
    assign dir_bios   = ch2 && bus_cycle.mem_read && bus_cycle.io_write
                        && bios_sel;
    assign dir_dor    = ch2 && bus_cycle.io_read && bus_cycle.mem_write
                        && floppy_dor[DOR_DMA_BIT];

    // Status port reads with IDE absent are answered on SD7 alone
    assign io_oe = periph_hits.any_enabled
                   && !(bus_cycle.io_read && status_addr && !ide_enable)
                   && !(periph_hits.floppy && !state.floppy_present);

    always_comb
    begin
        if (bus_cycle.dma)
            oe = ch2;
        else if (mem_cyc)
            oe = bios_sel;
        else if (io_cyc)
            oe = io_oe;
        else
            oe = 1'h0;
    end

    always_comb
    begin
        onehot_n = 3'h7;
        for (int k = 0; k < N && k < 3; k++)
            onehot_n[k] = !(io_cyc && master && window_hit[k]);
        code = (io_cyc && master) ? encode_select(periph_hits, window_hit)
                                  : CODE_IDLE;
    end

    // ************************************************************
    // State
    // ************************************************************

    always_comb
    begin
        next_state = state;
        // Synchronisers keep running in reset so the straps are fresh at release
        next_state.strap_sync = {state.strap_sync[0], disk_change_strap};
        next_state.pin_sync   = {state.pin_sync[0], select0_in};
        if (!reset_n)
        begin
            next_state.strap_pending = RST_STRAP;
            next_state.cram_rd_n     = RST_STROBE_N;
            next_state.cram_wr_n     = RST_STROBE_N;
            next_state.dir           = RST_DIR;
            next_state.oe_n          = RST_OE_N;
            next_state.pins          = RST_PINS;
            next_state.pin0_oe       = 1'h0;
        end
        else
        begin
            if (state.strap_pending)
            begin
                next_state.strap_pending  = 1'h0;
                next_state.test_select    = state.pin_sync[1];
                next_state.floppy_present = state.strap_sync[1];
            end
            // Captured straps are left alone until the next reset
            next_state.pin0_oe   = 1'h1;
            next_state.cram_rd_n = !(master && bus_cycle.io_read && cram_hit);
            next_state.cram_wr_n = !(master && bus_cycle.io_write && cram_hit);
            next_state.dir       = dir_master || dir_bios || dir_dor;
            next_state.oe_n      = !oe;
            next_state.pins      = encoded ? code : onehot_n;
        end
    end

    // Clock enable also holds off reset; keep it high while reset is applied
    always_ff @(posedge ref_clk)
    begin
        if (ce)
            state <= next_state;
    end

    assign cfg_ram_read_strobe_n       = state.cram_rd_n;
    assign cfg_ram_write_strobe_n      = state.cram_wr_n;
    assign periph_xcvr_direction       = state.dir;
    assign periph_xcvr_output_enable_n = state.oe_n;
    assign select_out                  = state.pins;
    assign select0_oe                  = state.pin0_oe;
    assign test_mode_select            = state.test_select;
    assign floppy_present              = state.floppy_present;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    sequence release_edge;
        $rose(reset_n) && ce;
    endsequence

    sequence strap_taken;
        ##1 select0_oe && test_mode_select == $past(state.pin_sync[1]);
    endsequence

    cram_read_a: assert property (
        ce && master && bus_cycle.io_read && cram_hit |=> !cfg_ram_read_strobe_n)
        else $error("config RAM read strobe missing");

    cram_write_a: assert property (
        ce |=> cfg_ram_write_strobe_n
               == !$past(master && bus_cycle.io_write && cram_hit))
        else $error("config RAM write strobe wrong");

    dir_master_a: assert property (
        ce && master && bus_cycle.mem_read |=> periph_xcvr_direction)
        else $error("direction not transmit on master read");

    dir_bios_a: assert property (
        ce && ch2 && bus_cycle.mem_read && bus_cycle.io_write && bios_sel
        |=> periph_xcvr_direction)
        else $error("direction not transmit on DMA BIOS read");

    dir_dor_a: assert property (
        ce && ch2 && bus_cycle.io_read && bus_cycle.mem_write
        && floppy_dor[DOR_DMA_BIT] |=> periph_xcvr_direction)
        else $error("direction not transmit on DMA DOR case");

    dir_idle_a: assert property (
        ce && !(bus_cycle.io_read || bus_cycle.mem_read) |=> !periph_xcvr_direction)
        else $error("direction not receive when idle");

    oe_mem_a: assert property (
        ce && master && mem_cyc |=> periph_xcvr_output_enable_n == !$past(bios_sel))
        else $error("memory cycle enable wrong");

    oe_status_a: assert property (
        ce && master && !mem_cyc && bus_cycle.io_read && status_addr && !ide_enable
        |=> periph_xcvr_output_enable_n)
        else $error("enable on status read with IDE off");

    oe_floppy_a: assert property (
        ce && master && !mem_cyc && io_cyc && periph_hits.floppy && !floppy_present
        |=> periph_xcvr_output_enable_n)
        else $error("enable on floppy with strap low");

    oe_dma_a: assert property (
        ce && bus_cycle.dma |=> periph_xcvr_output_enable_n == !$past(ch2))
        else $error("DMA enable wrong");

    sel_mode_a: assert property (
        ce && encoded && !(io_cyc && master) |=> select_out == CODE_IDLE)
        else $error("encoded select not idle");

    strap_a: assert property (
        release_edge |-> !select0_oe ##0 strap_taken)
        else $error("strap not captured at release");

    strap_hold_a: assert property (
        !state.strap_pending && $past(reset_n) |=> $stable(floppy_present))
        else $error("strap value changed after capture");

    dir_io_read_a: assert property (
        ce && master && bus_cycle.io_read |=> periph_xcvr_direction)
        else $error("direction not transmit on master I/O read");

    cram_dma_a: assert property (
        ce && bus_cycle.dma |=> cfg_ram_read_strobe_n && cfg_ram_write_strobe_n)
        else $error("config RAM strobe on DMA cycle");

    oe_io_a: assert property (
        ce && master && !mem_cyc && io_cyc && periph_hits.any_enabled
        && !periph_hits.floppy && !status_addr |=> !periph_xcvr_output_enable_n)
        else $error("enable missing on decoded peripheral");

    sel_onehot_a: assert property (
        ce && !encoded && master && io_cyc && window_hit[0] |=> !select_out[0])
        else $error("one-hot select 0 missing inside window");

    sel_dma_a: assert property (
        ce && !encoded && bus_cycle.dma |=> select_out == 3'h7)
        else $error("one-hot select on DMA cycle");

    sel_code_a: assert property (
        ce && encoded && master && io_cyc && periph_hits.serial_a
        |=> select_out == CODE_SERIAL_A)
        else $error("encoded select not serial A");

    pin_driven_a: assert property (
        ce && !state.strap_pending |=> select0_oe)
        else $error("select pin 0 not driven after reset");

endmodule

/* xbus_decode.sv */
package xbus_pkg;

    // ************************************************************
    // Widths and fixed addresses
    // ************************************************************
    localparam int          ADDR_W          = 16;
    localparam int          GP_COUNT        = 3;
    localparam logic [15:0] FDC_STAT_PRI    = 16'h03F7;
    localparam logic [15:0] FDC_STAT_SEC    = 16'h0377;
    localparam logic [2:0]  DMA_FDC_CHANNEL = 3'h2;
    localparam int          DOR_DMA_BIT     = 3;
    localparam int          MODE_ENC_BIT    = 4;

    // ************************************************************
    // Encoded select codes, expanded outside by a 3-to-8 decoder
    // ************************************************************
    localparam logic [2:0]  CODE_SERIAL_A   = 3'h0;
    localparam logic [2:0]  CODE_SERIAL_B   = 3'h1;
    localparam logic [2:0]  CODE_PARALLEL   = 3'h2;
    localparam logic [2:0]  CODE_IDE        = 3'h3;
    localparam logic [2:0]  CODE_GP0        = 3'h4;
    localparam logic [2:0]  CODE_IDLE       = 3'h7;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic        RST_STROBE_N    = 1'h1;
    localparam logic        RST_DIR         = 1'h0;
    localparam logic        RST_OE_N        = 1'h1;
    localparam logic [2:0]  RST_PINS        = 3'h7;
    localparam logic        RST_STRAP       = 1'h1;

    typedef struct packed {
        logic              io_read;
        logic              io_write;
        logic              mem_read;
        logic              mem_write;
        logic              dma;
        logic [2:0]        dma_channel;
        logic [ADDR_W-1:0] address;
    } cycle_type;

    typedef struct packed {
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] mask;
    } window_type;

    typedef struct packed {
        logic serial_a;
        logic serial_b;
        logic parallel;
        logic ide;
        logic floppy;
        logic any_enabled;
    } hits_type;

    typedef struct packed {
        logic [1:0] strap_sync;
        logic [1:0] pin_sync;
        logic       strap_pending;
        logic       floppy_present;
        logic       test_select;
        logic       cram_rd_n;
        logic       cram_wr_n;
        logic       dir;
        logic       oe_n;
        logic [2:0] pins;
        logic       pin0_oe;
    } state_type;

endpackage

`timescale 1ns/100ps

module xbus_decode
    import xbus_pkg::*;
#(
    parameter int N = GP_COUNT
)
(
    // Latched cycle address
    input  wire logic [ADDR_W-1:0] address,
    // Ranges and windows
    input  wire logic [ADDR_W-1:0] cram_low,
    input  wire logic [ADDR_W-1:0] cram_high,
    input  wire window_type [N-1:0] windows,
    // Hits
    output logic                   cram_hit,
    output logic [N-1:0]           window_hit,
    output logic                   status_addr
);

    // Mask bits set to one are don't-care address bits
    function automatic logic window_match(
        input logic [ADDR_W-1:0] a,
        input window_type        w
    );
        window_match = ((a ^ w.base) & ~w.mask) == '0;
    endfunction

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_win
            assign window_hit[i] = window_match(address, windows[i]);
        end
    endgenerate

    assign cram_hit    = (address >= cram_low) && (address <= cram_high);
    assign status_addr = (address == FDC_STAT_PRI) || (address == FDC_STAT_SEC);

endmodule

/* xbus_periph_model.sv */
`timescale 1ns/100ps

module xbus_periph_model
    import xbus_pkg::*;
(
    // Device side
    input  wire logic [2:0] select_out,
    input  wire logic       select0_oe,
    input  wire logic       encoded_mode,
    // Board strap on select pin 0
    input  wire logic       pin_pull_low,
    // Pin level and expanded selects
    output logic            select0_in,
    output logic [7:0]      decoded_select_n
);

    // ************************************************************
    // Shared select pin 0
    // ************************************************************
    // A released pin settles to its strap resistor, never to the last driven level
    assign select0_in = select0_oe ? select_out[0] : !pin_pull_low;

    // ************************************************************
    // Outside 3-to-8 expansion
    // ************************************************************
    always_comb
    begin
        decoded_select_n = 8'hFF;
        if (encoded_mode)
        begin
            decoded_select_n[select_out] = 1'h0;
        end
    end
endmodule

/* xbus_control_tb_top.sv */
`timescale 1ns/100ps

`define CHECK(what, exp, got) \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
        errors++; \
        $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
    end

module xbus_control_tb_top
    import xbus_pkg::*;
;
    localparam logic [3:0] IO_RD  = 4'h8;
    localparam logic [3:0] IO_WR  = 4'h4;
    localparam logic [3:0] MEM_RD = 4'h2;
    localparam logic [3:0] MEM_WR = 4'h1;

    logic                ref_clk;
    logic                reset_n;
    logic                ce;
    cycle_type           bus_cycle;
    logic [15:0]         cram_low;
    logic [15:0]         cram_high;
    window_type [2:0]    gp_window;
    logic [7:0]          mode_select;
    logic [7:0]          floppy_dor;
    logic                ide_enable;
    hits_type            periph_hits;
    logic                local_bios_select_n;
    logic                disk_change_strap;
    logic                select0_in;
    logic                pin_pull_low;
    logic                rd_n;
    logic                wr_n;
    logic                dir;
    logic                oe_n;
    logic [2:0]          select_out;
    logic                select0_oe;
    logic                test_mode_select;
    logic                floppy_present;
    logic [7:0]          decoded_select_n;
    int                  errors;
    int                  check_count;
    logic [5:0]          enc_hits [9] = '{6'h21, 6'h11, 6'h09, 6'h05, 6'h00, 6'h00, 6'h00,
                                          6'h00, 6'h21};
    logic [15:0]         enc_addr [9] = '{16'h03F8, 16'h02F8, 16'h0378, 16'h01F0, 16'h0304,
                                          16'h0309, 16'h0310, 16'h0400, 16'h0304};

    xbus_control DUT (
        .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .bus_cycle(bus_cycle),
        .cram_low(cram_low), .cram_high(cram_high), .gp_window(gp_window),
        .mode_select(mode_select), .floppy_dor(floppy_dor), .ide_enable(ide_enable),
        .periph_hits(periph_hits), .local_bios_select_n(local_bios_select_n),
        .disk_change_strap(disk_change_strap), .select0_in(select0_in),
        .cfg_ram_read_strobe_n(rd_n), .cfg_ram_write_strobe_n(wr_n),
        .periph_xcvr_direction(dir), .periph_xcvr_output_enable_n(oe_n),
        .select_out(select_out), .select0_oe(select0_oe),
        .test_mode_select(test_mode_select), .floppy_present(floppy_present));

    xbus_periph_model far_side (
        .select_out(select_out), .select0_oe(select0_oe),
        .encoded_mode(mode_select[MODE_ENC_BIT]), .pin_pull_low(pin_pull_low),
        .select0_in(select0_in), .decoded_select_n(decoded_select_n));

    // ************************************************************
    // Clock, watchdog and closing
    // ************************************************************
    initial
    begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        $display("watchdog expired");
        final_report();
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ************************************************************
    // Access tasks
    // ************************************************************
    // Outputs answer at the edge that samples the cycle, one cycle after it is driven
    task automatic xfer(input logic [3:0] kind, input logic dma, input logic [2:0] ch,
                        input logic [15:0] addr, input logic [5:0] hits, input logic bios_n,
                        input logic [3:0] exp_ctl, input logic [2:0] exp_sel);
        @(posedge ref_clk);
        bus_cycle <= cycle_type'({kind, dma, ch, addr});
        periph_hits <= hits_type'(hits);
        local_bios_select_n <= bios_n;
        @(posedge ref_clk);
        #1;
        `CHECK("rd wr dir oe", exp_ctl, {rd_n, wr_n, dir, oe_n})
        `CHECK("select pins", exp_sel, select_out)
    endtask

    task automatic do_reset(input logic dsk, input logic pull_low, input logic [1:0] exp_straps);
        @(posedge ref_clk);
        reset_n <= 1'h0;
        bus_cycle <= '0;
        disk_change_strap <= dsk;
        pin_pull_low <= pull_low;
        repeat (5) @(posedge ref_clk);
        #1;
        `CHECK("outputs in reset", 8'hDE, {rd_n, wr_n, dir, oe_n, select_out, select0_oe})
        @(posedge ref_clk);
        reset_n <= 1'h1;
        @(posedge ref_clk);
        #1;
        `CHECK("straps", exp_straps, {test_mode_select, floppy_present})
        @(posedge ref_clk);
        #1;
        `CHECK("pin 0 driven", 1'h1, select0_oe)
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        errors = 0;
        check_count = 0;
        reset_n = 1'h0;
        ce = 1'h1;
        bus_cycle = '0;
        cram_low = 16'h0C00;
        cram_high = 16'h0C0F;
        gp_window[0] = window_type'({16'h0300, 16'h0007});
        gp_window[1] = window_type'({16'h0308, 16'h0001});
        gp_window[2] = window_type'({16'h0310, 16'h0000});
        mode_select = 8'h00;
        floppy_dor = 8'h00;
        ide_enable = 1'h0;
        periph_hits = '0;
        local_bios_select_n = 1'h1;
        disk_change_strap = 1'h0;
        pin_pull_low = 1'h1;
        do_reset(1'h0, 1'h1, 2'h0);
        $display("test straps low done");
        xfer(IO_RD, 0, 0, 16'h0C00, 6'h00, 1, 4'h7, 3'h7);
        xfer(IO_RD, 0, 0, 16'h0C0F, 6'h00, 1, 4'h7, 3'h7);
        xfer(IO_RD, 0, 0, 16'h0C10, 6'h00, 1, 4'hF, 3'h7);
        xfer(IO_WR, 0, 0, 16'h0C0F, 6'h00, 1, 4'h9, 3'h7);
        xfer(IO_WR, 0, 0, 16'h0BFF, 6'h00, 1, 4'hD, 3'h7);
        xfer(4'h6, 1, 2, 16'h0C00, 6'h00, 1, 4'hC, 3'h7);
        xfer(IO_RD, 0, 0, 16'h0C00, 6'h00, 1, 4'h7, 3'h7);
        @(posedge ref_clk);
        ce <= 1'h0;
        bus_cycle <= '0;
        repeat (3) @(posedge ref_clk);
        #1;
        `CHECK("frozen read strobe", 1'h0, rd_n)
        @(posedge ref_clk);
        ce <= 1'h1;
        @(posedge ref_clk);
        #1;
        `CHECK("released read strobe", 1'h1, rd_n)
        $display("test config ram done");
        xfer(MEM_RD, 0, 0, 16'hF000, 6'h00, 0, 4'hE, 3'h7);
        xfer(MEM_RD, 0, 0, 16'hF000, 6'h00, 1, 4'hF, 3'h7);
        xfer(MEM_WR, 0, 0, 16'hF000, 6'h00, 0, 4'hC, 3'h7);
        xfer(MEM_WR, 0, 0, 16'hF000, 6'h00, 1, 4'hD, 3'h7);
        xfer(IO_WR, 0, 0, 16'h03F8, 6'h21, 1, 4'hC, 3'h7);
        xfer(IO_RD, 0, 0, 16'h0378, 6'h09, 1, 4'hE, 3'h7);
        xfer(IO_WR, 0, 0, 16'h0378, 6'h00, 1, 4'hD, 3'h7);
        xfer(IO_WR, 0, 0, 16'h03F2, 6'h03, 1, 4'hD, 3'h7);
        xfer(IO_RD, 0, 0, 16'h03F2, 6'h03, 1, 4'hF, 3'h7);
        $display("test master transceiver done");
        @(posedge ref_clk);
        floppy_dor <= 8'h08;
        xfer(4'h6, 1, 2, 16'h0000, 6'h00, 0, 4'hE, 3'h7);
        xfer(4'h6, 1, 2, 16'h0000, 6'h00, 1, 4'hC, 3'h7);
        xfer(4'h9, 1, 2, 16'h0000, 6'h00, 1, 4'hE, 3'h7);
        xfer(4'h9, 1, 1, 16'h0000, 6'h00, 1, 4'hD, 3'h7);
        xfer(4'h6, 1, 1, 16'h0000, 6'h00, 0, 4'hD, 3'h7);
        @(posedge ref_clk);
        floppy_dor <= 8'hF7;
        xfer(4'h9, 1, 2, 16'h0000, 6'h00, 1, 4'hC, 3'h7);
        $display("test dma done");
        xfer(IO_WR, 0, 0, 16'h0304, 6'h00, 1, 4'hD, 3'h6);
        xfer(IO_RD, 0, 0, 16'h0309, 6'h00, 1, 4'hF, 3'h5);
        xfer(IO_RD, 0, 0, 16'h0310, 6'h00, 1, 4'hF, 3'h3);
        xfer(IO_RD, 0, 0, 16'h0311, 6'h00, 1, 4'hF, 3'h7);
        xfer(4'h9, 1, 1, 16'h0304, 6'h00, 1, 4'hD, 3'h7);
        xfer(MEM_RD, 0, 0, 16'h0304, 6'h00, 1, 4'hF, 3'h7);
        @(posedge ref_clk);
        mode_select <= 8'h10;
        for (int i = 0; i < 9; i++)
        begin
            xfer(IO_WR, 0, 0, enc_addr[i], enc_hits[i], 1, enc_hits[i][0] ? 4'hC : 4'hD,
                 (i == 8) ? 3'h0 : 3'(i));
            `CHECK("expanded selects", ~(8'h01 << ((i == 8) ? 0 : i)), decoded_select_n)
        end
        $display("test chip selects done");
        mode_select <= 8'h00;
        do_reset(1'h1, 1'h0, 2'h3);
        @(posedge ref_clk);
        disk_change_strap <= 1'h0;
        pin_pull_low <= 1'h1;
        repeat (4) @(posedge ref_clk);
        #1;
        `CHECK("straps held", 2'h3, {test_mode_select, floppy_present})
        xfer(IO_RD, 0, 0, 16'h03F7, 6'h03, 1, 4'hF, 3'h7);
        xfer(IO_RD, 0, 0, 16'h0377, 6'h03, 1, 4'hF, 3'h7);
        xfer(IO_WR, 0, 0, 16'h03F7, 6'h03, 1, 4'hC, 3'h7);
        xfer(IO_WR, 0, 0, 16'h03F2, 6'h03, 1, 4'hC, 3'h7);
        @(posedge ref_clk);
        ide_enable <= 1'h1;
        xfer(IO_RD, 0, 0, 16'h03F7, 6'h03, 1, 4'hE, 3'h7);
        $display("test floppy present done");
        final_report();
    end
endmodule
